// file: flash_gate_consts.vh
`ifndef FLASH_GATE_CONSTS_VH
`define FLASH_GATE_CONSTS_VH

// ==========================================================
// Opcodes
`define OP_ERASE_ALL_A   8'h60
`define OP_ERASE_ALL_B   8'hc7
`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_STATUS_WRITE  8'h01

// ==========================================================
// Protection settings field layout in the status write byte
`define PROT_LEVEL_LSB   0
`define PROT_LEVEL_MSB   2
`define PROT_TB_BIT      3
`define PROT_GRAN_BIT    4
`define PROT_CMP_BIT     5
`define PROT_WIDTH       6
`define PROT_RESET       6'h00

// ==========================================================
// Array geometry in 4-Kbyte units
`define UNITS_ALL        9'h100
`define UNITS_NONE       9'h000
`define UNIT_LAST        8'hff
`define UNIT_LOW_FILL    12'hfff
`define UNIT_LOW_ZERO    12'h000
`define UNITS_ONE        9'h001
`define UNITS_SIXTEENTH  9'h010
`define UNITS_FINE_TOP   9'h008

// ==========================================================
// Protect level bounds for the size decode
`define LEVEL_NONE       3'h0
`define LEVEL_ONE        3'h1
`define LEVEL_HALF       3'h4
`define LEVEL_FINE_64    3'h3
`define LEVEL_FINE_32    3'h5
`define ADDR_ZERO        20'h00000
`define ERASED_BYTE      8'hff

// ==========================================================
// Link framing
`define BIT_IDX_ZERO     3'h0
`define BIT_IDX_LAST     3'h7
`define BYTES_ZERO       2'h0
`define BYTES_ONE        2'h1
`define BYTES_TWO        2'h2
`define BYTES_MAX        2'h3
`define CYC_ZERO         32'h00000000
`define CYC_ONE          32'h00000001

// ==========================================================
// Timing: erase time in microseconds, clock in MHz
`define ERASE_TIME_US    32'd2000
`define CLK_MHZ          32'd100

`endif

// file: flash_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the serial link, mode 0
module flash_host_model
(
   input  wire clk_in,
   output reg  cs_n_out,
   output reg  sck_out,
   output reg  si_out
);
   // Link idle: select high, clock parked low
   initial
   begin
      cs_n_out = 1'b1;
      sck_out  = 1'b0;
      si_out   = 1'b0;
   end

   // One frame, MSB first from the top of the word; 80 ns link clock
   task frame(input [15:0] word, input [4:0] nbits);
      integer b;
      begin
         @(posedge clk_in);
         cs_n_out <= 1'b0;
         repeat (4) @(posedge clk_in);
         for (b = 0; b < nbits; b = b + 1)
         begin
            si_out <= word[15 - b];
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b0;
         end
         repeat (4) @(posedge clk_in);
         cs_n_out <= 1'b1;
         si_out   <= ~si_out; // Released line shows no stale bit
         repeat (12) @(posedge clk_in); // Keeps select high between frames
      end
   endtask
endmodule

// file: prot_range_decode.v
`timescale 1ns/1ps
`include "flash_gate_consts.vh"

// Turns the six protection settings into a range of 4-Kbyte units
module prot_range_decode
(
   input  wire [5:0]  settings_in,
   output reg  [19:0] start_addr_out,
   output reg  [19:0] end_addr_out,
   output reg         nonempty_out
);

   reg [2:0] level;
   reg       gran;
   reg       tb;
   reg       cmp;
   reg [8:0] units;
   reg [8:0] units_eff;
   reg       at_top;
   reg [8:0] top_gap;
   reg [8:0] bot_last;

   // ==========================================================
   // Region size, then complement and placement
   always @*
   begin
      level = settings_in[`PROT_LEVEL_MSB:`PROT_LEVEL_LSB];
      gran  = settings_in[`PROT_GRAN_BIT];
      tb    = settings_in[`PROT_TB_BIT];
      cmp   = settings_in[`PROT_CMP_BIT];
      units = `UNITS_NONE;
      if (level == `LEVEL_NONE)
         units = `UNITS_NONE;
      else if (!gran)
      begin
         if (level <= `LEVEL_HALF)
            units = `UNITS_SIXTEENTH << (level - `LEVEL_ONE);
         else
            units = `UNITS_ALL;
      end
      else
      begin
         if (level <= `LEVEL_FINE_64)
            units = `UNITS_ONE << (level - `LEVEL_ONE);
         else if (level <= `LEVEL_FINE_32)
            units = `UNITS_FINE_TOP;
         else
            units = `UNITS_ALL;
      end
      // Complement flips both size and side
      units_eff = cmp ? (`UNITS_ALL - units) : units;
      at_top    = cmp ? tb : ~tb;
      // Whole array at the top leaves no gap, so its start is zero
      top_gap   = `UNITS_ALL - units_eff;
      bot_last  = units_eff - `UNITS_ONE;
      nonempty_out = (units_eff != `UNITS_NONE);
      if (at_top)
      begin
         start_addr_out = {top_gap[7:0], `UNIT_LOW_ZERO};
         end_addr_out   = {`UNIT_LAST, `UNIT_LOW_FILL};
      end
      else
      begin
         start_addr_out = `ADDR_ZERO;
         end_addr_out   = {bot_last[7:0], `UNIT_LOW_FILL};
      end
      // Empty region reports a null range
      if (!nonempty_out)
      begin
         start_addr_out = `ADDR_ZERO;
         end_addr_out   = `ADDR_ZERO;
      end
   end

endmodule

// file: test_write_gate_chip_erase_protect.sv
`timescale 1ns/1ps
module test_write_gate_chip_erase_protect;
   reg         clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         wp_n = 1'b1;
   wire        cs_n, sck, si, latch, busy, start, active;
   wire [7:0]  fill;
   wire [5:0]  sets;
   wire [19:0] p_lo, p_hi;
   integer     n_errors = 0, n_tests = 0, n_start = 0, cyc = 0, i, k;
   reg  [45:0] tbl [0:7];

   flash_host_model i_host (.clk_in(clk), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
   write_gate_chip_erase_protect #(.ERASE_CYCLES(50)) i_dut (.CLK_IN(clk),
      .ARST_N_IN(arst_n), .CS_N_IN(cs_n), .SCK_IN(sck), .SI_IN(si), .WP_N_IN(wp_n),
      .WRITE_LATCH_OUT(latch), .BUSY_OUT(busy), .ERASE_START_OUT(start),
      .ERASE_FILL_OUT(fill), .PROT_SETTINGS_OUT(sets), .PROT_START_OUT(p_lo),
      .PROT_END_OUT(p_hi), .PROT_ACTIVE_OUT(active));

   // ==========================================
   // Clock, erase-start count and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      n_start = n_start + (start === 1'b1);
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         give_verdict;
      end
   end

   // ==========================================
   // Checking and command tasks
   task chk(input [19:0] got, input [19:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task op8(input [7:0] op);
      i_host.frame({op, 8'h00}, 5'd8);
   endtask
   // Latch first, as modifying commands demand
   task wr_status(input [5:0] s);
      begin
         op8(8'h06);
         i_host.frame({8'h01, 2'b00, s}, 5'd16);
      end
   endtask
   // Host polls busy instead of sitting out the longest erase
   task erase_ok(input [7:0] op);
      begin
         op8(8'h06);
         k = n_start;
         i_host.frame({op, 8'h5a}, 5'd16);
         chk(20'(n_start - k), 20'h1);
         chk(busy, 1'b1);
         chk(latch, 1'b0);
         i = 0;
         while (busy === 1'b1 && i < 200)
         begin
            @(posedge clk);
            i = i + 1;
         end
         chk(busy, 1'b0);
      end
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      tbl[0] = {6'h01, 20'hf0000, 20'hfffff};
      tbl[1] = {6'h0c, 20'h00000, 20'h7ffff};
      tbl[2] = {6'h06, 20'h00000, 20'hfffff};
      tbl[3] = {6'h19, 20'h00000, 20'h00fff};
      tbl[4] = {6'h14, 20'hf8000, 20'hfffff};
      tbl[5] = {6'h25, 20'h00000, 20'h00000};
      tbl[6] = {6'h3b, 20'h04000, 20'hfffff};
      tbl[7] = {6'h21, 20'h00000, 20'heffff};
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(fill, 8'hff);
      chk({latch, busy, sets}, 8'h00);
      $display("Test reset done");
      op8(8'h06);
      chk(latch, 1'b1);
      i_host.frame(16'h04a5, 5'd16);
      chk(latch, 1'b0);
      i_host.frame(16'h0600, 5'd7);
      chk(latch, 1'b0);
      op8(8'h06);
      i_host.frame(16'h0400, 5'd12);
      chk(latch, 1'b1);
      op8(8'h04);
      op8(8'h60);
      chk(busy, 1'b0);
      op8(8'h06);
      i_host.frame(16'h6000, 5'd12);
      chk({busy, latch}, 2'b00);
      $display("Test latch and refusals done");
      for (i = 0; i < 8; i = i + 1)
      begin
         wr_status(tbl[i][45:40]);
         chk(sets, tbl[i][45:40]);
         chk(p_lo, tbl[i][39:20]);
         chk(p_hi, tbl[i][19:0]);
         chk(active, |tbl[i][19:0]);
      end
      op8(8'h06);
      op8(8'h60);
      chk({busy, latch}, 2'b00);
      wp_n <= 1'b0;
      wr_status(6'h00);
      chk(sets, 6'h21);
      wp_n <= 1'b1;
      wr_status(6'h00);
      chk({active, sets}, 7'h00);
      $display("Test protection done");
      erase_ok(8'h60);
      erase_ok(8'hc7);
      $display("Test erase done");
      give_verdict;
   end
endmodule

// file: write_gate_chip_erase_protect.v
`timescale 1ns/1ps
`include "flash_gate_consts.vh"

// Command gate for the serial flash: latch commands, whole-array
// erase, status write of the protection settings and range decode.
module write_gate_chip_erase_protect
#(
   parameter ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
)
(
   input  wire        CLK_IN,
   input  wire        ARST_N_IN,
   input  wire        CS_N_IN,
   input  wire        SCK_IN,
   input  wire        SI_IN,
   input  wire        WP_N_IN,
   output reg         WRITE_LATCH_OUT,
   output reg         BUSY_OUT,
   output reg         ERASE_START_OUT,
   output reg  [7:0]  ERASE_FILL_OUT,
   output reg  [5:0]  PROT_SETTINGS_OUT,
   output reg  [19:0] PROT_START_OUT,
   output reg  [19:0] PROT_END_OUT,
   output reg         PROT_ACTIVE_OUT
);

   // ==========================================================
   // Pin synchronisers
   reg [1:0] cs_sync_r;
   reg [1:0] sck_sync_r;
   reg [1:0] si_sync_r;
   reg [1:0] wp_sync_r;
   reg       sck_prev_r;
   reg       cs_prev_r;

   // Two flops on every pin; only the second stage is read
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         cs_sync_r  <= 2'h3;
         sck_sync_r <= 2'h0;
         si_sync_r  <= 2'h0;
         wp_sync_r  <= 2'h3;   // Idle level, no lock seen out of reset
         sck_prev_r <= 1'b0;
         cs_prev_r  <= 1'b1;
      end
      else
      begin
         cs_sync_r  <= {cs_sync_r[0], CS_N_IN};
         sck_sync_r <= {sck_sync_r[0], SCK_IN};
         si_sync_r  <= {si_sync_r[0], SI_IN};
         wp_sync_r  <= {wp_sync_r[0], WP_N_IN};
         sck_prev_r <= sck_sync_r[1];
         cs_prev_r  <= cs_sync_r[1];
      end
   end

   wire cs_n     = cs_sync_r[1];
   wire sck_rise = sck_sync_r[1] & ~sck_prev_r & ~cs_n;
   wire cs_start = cs_prev_r & ~cs_n;
   wire cs_end   = ~cs_prev_r & cs_n;
   wire wp_n     = wp_sync_r[1];

   // ==========================================================
   // Frame capture: bit index, byte count, opcode and data byte
   reg [2:0] bit_idx_r;
   reg [1:0] bytes_r;
   reg [7:0] shift_r;
   reg [7:0] opcode_r;
   reg [7:0] data_r;

   wire [7:0] shift_nxt = {shift_r[6:0], si_sync_r[1]};

   // Bits after the second byte are counted for alignment only
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         bit_idx_r <= `BIT_IDX_ZERO;
         bytes_r   <= `BYTES_ZERO;
         shift_r   <= 8'h00;
         opcode_r  <= 8'h00;
         data_r    <= 8'h00;
      end
      else if (cs_start)
      begin
         bit_idx_r <= `BIT_IDX_ZERO;
         bytes_r   <= `BYTES_ZERO;
      end
      else if (sck_rise)
      begin
         shift_r   <= shift_nxt;
         bit_idx_r <= bit_idx_r + 3'h1;
         if (bit_idx_r == `BIT_IDX_LAST)
         begin
            if (bytes_r == `BYTES_ZERO)
               opcode_r <= shift_nxt;
            if (bytes_r == `BYTES_ONE)
               data_r <= shift_nxt;
            if (bytes_r != `BYTES_MAX)
               bytes_r <= bytes_r + 2'h1;
         end
      end
   end

   // Erase-all opcode decode, used only by the erase check
   function is_erase_all;
      input [7:0] op;
      begin
         is_erase_all = (op == `OP_ERASE_ALL_A) || (op == `OP_ERASE_ALL_B);
      end
   endfunction

   wire on_boundary = (bit_idx_r == `BIT_IDX_ZERO);
   wire have_opcode = (bytes_r != `BYTES_ZERO);
   wire whole_frame = on_boundary & have_opcode;

   // ==========================================================
   // Protection range decode
   reg  [5:0]  prot_r;
   wire [19:0] range_start;
   wire [19:0] range_end;
   wire        range_nonempty;

   prot_range_decode u_decode
   (
      .settings_in    (prot_r),
      .start_addr_out (range_start),
      .end_addr_out   (range_end),
      .nonempty_out   (range_nonempty)
   );

   // ==========================================================
   // Command execution and erase timer
   reg        latch_r;
   reg        busy_r;
   reg        start_r;
   reg [31:0] erase_cnt_r;
   reg        latch_nxt;
   reg        busy_nxt;
   reg        start_nxt;
   reg [5:0]  prot_nxt;
   reg [31:0] erase_cnt_nxt;

   // Commands decided on the select release; busy ignores new ones
   always @*
   begin
      latch_nxt     = latch_r;
      busy_nxt      = busy_r;
      start_nxt     = 1'b0;
      prot_nxt      = prot_r;
      erase_cnt_nxt = erase_cnt_r;
      if (busy_r)
      begin
         if (erase_cnt_r <= `CYC_ONE)
            busy_nxt = 1'b0;
         else
            erase_cnt_nxt = erase_cnt_r - `CYC_ONE;
      end
      else if (cs_end && have_opcode)
      begin
         if (is_erase_all(opcode_r) && latch_r)
         begin
            // No address expected; extra whole bytes are ignored
            if (!on_boundary || range_nonempty)
               latch_nxt = 1'b0;
            else
            begin
               busy_nxt      = 1'b1;
               start_nxt     = 1'b1;
               latch_nxt     = 1'b0;
               erase_cnt_nxt = ERASE_CYCLES;
            end
         end
         else if (opcode_r == `OP_LATCH_SET && on_boundary)
            latch_nxt = 1'b1;
         else if (opcode_r == `OP_LATCH_CLEAR && on_boundary)
            latch_nxt = 1'b0;
         else if (opcode_r == `OP_STATUS_WRITE && latch_r)
         begin
            // Exactly one data byte; a grounded write-protect locks it
            if (on_boundary && bytes_r == `BYTES_TWO && wp_n)
               prot_nxt = data_r[`PROT_WIDTH-1:0];
            latch_nxt = 1'b0;
         end
      end
   end

   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         latch_r     <= 1'b0;
         busy_r      <= 1'b0;
         start_r     <= 1'b0;
         prot_r      <= `PROT_RESET;
         erase_cnt_r <= `CYC_ZERO;
      end
      else
      begin
         latch_r     <= latch_nxt;
         busy_r      <= busy_nxt;
         start_r     <= start_nxt;
         prot_r      <= prot_nxt;
         erase_cnt_r <= erase_cnt_nxt;
      end
   end

   // ==========================================================
   // Registered outputs, one cycle behind internal state
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         WRITE_LATCH_OUT   <= 1'b0;
         BUSY_OUT          <= 1'b0;
         ERASE_START_OUT   <= 1'b0;
         ERASE_FILL_OUT    <= `ERASED_BYTE;
         PROT_SETTINGS_OUT <= `PROT_RESET;
         PROT_START_OUT    <= `ADDR_ZERO;
         PROT_END_OUT      <= `ADDR_ZERO;
         PROT_ACTIVE_OUT   <= 1'b0;
      end
      else
      begin
         WRITE_LATCH_OUT   <= latch_r;
         BUSY_OUT          <= busy_r;
         ERASE_START_OUT   <= start_r;
         ERASE_FILL_OUT    <= `ERASED_BYTE;
         PROT_SETTINGS_OUT <= prot_r;
         PROT_START_OUT    <= range_start;
         PROT_END_OUT      <= range_end;
         PROT_ACTIVE_OUT   <= range_nonempty;
      end
   end

endmodule

// file: write_gate_chip_erase_protect_properties.sv
`timescale 1ns/1ps
module write_gate_chip_erase_protect_properties
#(
   parameter ERASE_CYCLES = 50
)
(
   input wire        CLK_IN,
   input wire        ARST_N_IN,
   input wire        CS_N_IN,
   input wire        SCK_IN,
   input wire        SI_IN,
   input wire        WP_N_IN,
   input wire        WRITE_LATCH_OUT,
   input wire        BUSY_OUT,
   input wire        ERASE_START_OUT,
   input wire [7:0]  ERASE_FILL_OUT,
   input wire [5:0]  PROT_SETTINGS_OUT,
   input wire [19:0] PROT_START_OUT,
   input wire [19:0] PROT_END_OUT,
   input wire        PROT_ACTIVE_OUT
);
   // ==========================================
   // Length of the current busy stretch
   reg [31:0] busy_cnt_r;
   always @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         busy_cnt_r <= 32'h0;
      else
         busy_cnt_r <= BUSY_OUT ? busy_cnt_r + 32'h1 : 32'h0;
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   // ==========================================
   // Erase start, latch and busy
   a_start_with_busy: assert property ($rose(BUSY_OUT) |-> ERASE_START_OUT)
      else $error("busy rose without erase start");
   a_start_one_cycle: assert property (ERASE_START_OUT |=> !ERASE_START_OUT)
      else $error("erase start longer than one cycle");
   a_start_latch_low: assert property (ERASE_START_OUT |-> !WRITE_LATCH_OUT)
      else $error("latch still set at erase start");
   a_start_needs_latch: assert property (ERASE_START_OUT |-> $past(WRITE_LATCH_OUT))
      else $error("erase started without latch");
   a_start_unprotected: assert property (ERASE_START_OUT |-> !PROT_ACTIVE_OUT)
      else $error("erase started on protected array");
   a_busy_length: assert property ($fell(BUSY_OUT) |->
      busy_cnt_r >= ERASE_CYCLES - 2 && busy_cnt_r <= ERASE_CYCLES + 2)
      else $error("busy length wrong");
   a_busy_quiet: assert property (BUSY_OUT && $past(BUSY_OUT) |->
      $stable(PROT_SETTINGS_OUT) && $stable(WRITE_LATCH_OUT))
      else $error("command acted on while busy");
   // ==========================================
   // Protection settings and erased value
   a_wp_freeze: assert property (!WP_N_IN [*8] |=> $stable(PROT_SETTINGS_OUT))
      else $error("settings changed with write-protect low");
   a_empty_zero: assert property (!PROT_ACTIVE_OUT |-> PROT_START_OUT == 20'h0
      && PROT_END_OUT == 20'h0)
      else $error("empty range not zero");
   a_fill_ones: assert property (ERASE_FILL_OUT == 8'hff)
      else $error("erased byte not all ones");

   c_erase: cover property (ERASE_START_OUT);
   c_refused: cover property ($fell(WRITE_LATCH_OUT) && !BUSY_OUT);
   c_protected: cover property (PROT_ACTIVE_OUT);
endmodule

bind write_gate_chip_erase_protect write_gate_chip_erase_protect_properties
   #(.ERASE_CYCLES(ERASE_CYCLES)) i_props (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
   .CS_N_IN(CS_N_IN), .SCK_IN(SCK_IN), .SI_IN(SI_IN), .WP_N_IN(WP_N_IN),
   .WRITE_LATCH_OUT(WRITE_LATCH_OUT), .BUSY_OUT(BUSY_OUT),
   .ERASE_START_OUT(ERASE_START_OUT), .ERASE_FILL_OUT(ERASE_FILL_OUT),
   .PROT_SETTINGS_OUT(PROT_SETTINGS_OUT), .PROT_START_OUT(PROT_START_OUT),
   .PROT_END_OUT(PROT_END_OUT), .PROT_ACTIVE_OUT(PROT_ACTIVE_OUT));
